// *** rtl/fmt_pkg.sv ***
// constants, modes and rule notes for the sample block output formatter
// assumes a single 100 MHz clock domain and plain configuration ports
// Functional notes
// [RL1] requested block length accepted from one up to half memory bytes
// [RL2] requested length rounded up to next power of two
// [RL3] out of range request clamps to nearest valid length, sets setup error
// [RL4] original request kept; later parameter change moves length nearer it
// [RL5] sample bytes: two, four, four or eight by kind and width
// [RL6] minimum lengths 3,2,2,1 register port and 6,3,3,2 byte port
// [RL7] maximum length 4M,2M,1M samples times memory multiplier
// [RL8] length read back is the effective length, not the request
// [RL9] trailer byte: bit0 overload, bit1 adc error, appended per block
// [RL10] register port trailer sits in low byte of word after last sample
// [RL11] byte port trailer goes as 32-bit word, its byte flagged last; code sends only the status byte, flagged last
// [RL12] reader fetches trailer word in its own separate access
// [RL13] register port 16-bit: one word per part, real then imaginary
// [RL14] register port 32-bit: high half then low half, real before imag
// [RL15] byte port: most significant byte first for each part
// [RL16] byte port 32-bit: four real bytes then four imaginary bytes
// [RL17] neighbour on the right must accept the emitted byte sequence
// [RL18] memory writes at most four bytes per clock, two in gapless mode
// [RL19] complex 32-bit needs extra decimation at full rate
// [RL20] mode permission table by width, kind, decimation and filter setting
// [RL21] reset: real, 32-bit, block mode, length 1024, no trailer, register port
// [RL22] changing a format or flow setting aborts the running measurement
// [RL23] block mode stops after each block; gapless runs on after one arm
// [RL24] complex output gives real then imaginary per sample
// [RL25] undefined trailer bits and upper word byte driven zero
// [RL26] effective length recomputed on kind, width or port change
package fmt_pkg;
	localparam int LEN_W = 26;
	localparam logic [LEN_W-1:0] RESET_LEN = 26'h0000400;
	localparam logic [LEN_W-1:0] BASE_MAX_2B = 26'h0400000;
	localparam logic [3:0] MIN_REG_R16 = 4'h3;
	localparam logic [3:0] MIN_REG_R32 = 4'h2;
	localparam logic [3:0] MIN_REG_C32 = 4'h1;
	localparam logic [3:0] MIN_BYTE_R16 = 4'h6;
	localparam logic [3:0] MIN_BYTE_R32 = 4'h3;
	localparam logic [3:0] MIN_BYTE_C32 = 4'h2;
	localparam logic [4:0] FILTER_NARROW = 5'h1;
	localparam logic [4:0] FILTER_TWO = 5'h2;
	localparam int OVERLOAD_BIT = 0;
	localparam int ADC_ERROR_BIT = 1;
	localparam logic [3:0] FULL_RATE_BYTES = 4'h4;
	localparam logic [3:0] GAPLESS_RATE_BYTES = 4'h2;
	typedef enum logic {kind_real_only, kind_real_imag} sample_kind_type;
	typedef enum logic {width_sixteen, width_thirtytwo} width_type;
	typedef enum logic {single_block_mode, gapless_run_mode} run_mode_type;
	typedef enum logic {register_read_port, neighbour_byte_port} port_type;
endpackage

// *** rtl/block_length_calc.sv ***
// effective block length from request, format and memory size
// assumes inputs are stable registered configuration
`timescale 1ns/10ps
`default_nettype none
module block_length_calc #(
	parameter int MEM_MULT = 1
) (
	input  wire logic [fmt_pkg::LEN_W-1:0] requested_len,
	input  wire fmt_pkg::sample_kind_type  kind,
	input  wire fmt_pkg::width_type        width,
	input  wire fmt_pkg::port_type         port,
	output logic [fmt_pkg::LEN_W-1:0]      effective_len,
	output logic                           out_of_range
);
	import fmt_pkg::*;
	initial begin
		if (MEM_MULT < 1 || MEM_MULT > 8) $error("memory multiplier unsupported");
	end
	// smallest power of two not below the request
	function automatic logic [LEN_W-1:0] ceil_pow2(input logic [LEN_W-1:0] v);
		logic [LEN_W-1:0] p;
		p = {{(LEN_W-1){1'b0}}, 1'b1};
		for (int i = 0; i < LEN_W-1; i++) begin
			if (p < v) p = p << 1;
		end
		return p;
	endfunction
	wire logic [3:0] sample_bytes;
	wire logic [3:0] min_len;
	wire logic [LEN_W-1:0] max_len;
	wire logic [LEN_W-1:0] rounded;
	// bytes per sample decide both ends of the range
	assign sample_bytes = (kind == kind_real_imag && width == width_thirtytwo) ? 4'h8 :
		(kind == kind_real_only && width == width_sixteen) ? 4'h2 : 4'h4; // RL5
	assign min_len = (port == register_read_port) ?
		(sample_bytes == 4'h2 ? MIN_REG_R16 : sample_bytes == 4'h4 ? MIN_REG_R32 : MIN_REG_C32) :
		(sample_bytes == 4'h2 ? MIN_BYTE_R16 : sample_bytes == 4'h4 ? MIN_BYTE_R32 : MIN_BYTE_C32); // RL6
	assign max_len = LEN_W'((BASE_MAX_2B * MEM_MULT) >> (sample_bytes == 4'h8 ? 2 : sample_bytes == 4'h4 ? 1 : 0)); // RL7
	assign rounded = ceil_pow2(requested_len); // RL2
	// clamp after rounding, so a bad request lands on the nearest end
	// a short request lands on the smallest power of two that meets the minimum
	assign effective_len = (requested_len < LEN_W'(min_len)) ? ceil_pow2(LEN_W'(min_len)) :
		(rounded > max_len) ? max_len : rounded; // RL3 RL26
	assign out_of_range = (requested_len < LEN_W'(min_len)) || (rounded > max_len); // RL3
endmodule
`default_nettype wire

// *** rtl/sample_serializer.sv ***
// splits one sample into output units: 16-bit words or bytes
// assumes the sample is held stable while busy
`timescale 1ns/10ps
`default_nettype none
module sample_serializer (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic                  load,
	input  wire logic [63:0]           sample_bits,
	input  wire logic [3:0]            unit_count,
	input  wire logic                  byte_units,
	input  wire logic                  unit_ready,
	output logic                       unit_valid,
	output logic [15:0]                unit_data,
	output logic                       busy,
	output logic                       last_unit
);
	import fmt_pkg::*;
	logic [63:0] shift_q;
	logic [3:0]  left_q;
	wire logic   take;
	// msb-first shift gives high half before low and real before imaginary
	assign take = unit_valid && unit_ready;
	assign unit_valid = (left_q != 4'h0);
	assign busy = unit_valid;
	assign last_unit = (left_q == 4'h1);
	assign unit_data = byte_units ? {8'h00, shift_q[63:56]} : shift_q[63:48]; // RL13 RL14 RL15 RL16
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= 64'h0000000000000000;
			left_q <= 4'h0;
		end else if (load && !busy) begin
			shift_q <= sample_bits;
			left_q <= unit_count;
		end else if (take) begin
			shift_q <= byte_units ? {shift_q[55:0], 8'h00} : {shift_q[47:0], 16'h0000};
			left_q <= left_q - 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** rtl/sample_block_output_formatter.sv ***
// top of the output formatter: config, block framing, trailer and two ports
// assumes the filter delivers samples with valid/ready on this clock
`timescale 1ns/10ps
`default_nettype none
module sample_block_output_formatter #(
	parameter int MEM_MULT = 1
) (
	input  wire logic                      clock,
	input  wire logic                      reset_n,
	// ************************************************
	// configuration
	// ************************************************
	input  wire logic                      cfg_write,
	input  wire fmt_pkg::sample_kind_type  cfg_kind,
	input  wire fmt_pkg::width_type        cfg_width,
	input  wire fmt_pkg::run_mode_type     cfg_mode,
	input  wire logic [fmt_pkg::LEN_W-1:0] cfg_len,
	input  wire logic                      cfg_trailer,
	input  wire fmt_pkg::port_type         cfg_port,
	input  wire logic [4:0]                filter_octave_setting,
	input  wire logic                      extra_decimate,
	output fmt_pkg::sample_kind_type       sample_kind_select,
	output fmt_pkg::width_type             width_now,
	output fmt_pkg::run_mode_type          mode_now,
	output logic                           trailer_status_enable,
	output fmt_pkg::port_type              port_now,
	output logic [fmt_pkg::LEN_W-1:0]      block_len_now,
	output logic                           setup_error,
	output logic                           mode_refused,
	output logic [3:0]                     rate_limit_bytes,
	// ************************************************
	// measurement and samples
	// ************************************************
	input  wire logic                      arm_trigger,
	input  wire logic                      adc_overload,
	input  wire logic                      adc_error,
	input  wire logic                      sample_valid,
	input  wire logic [31:0]               real_part_word,
	input  wire logic [31:0]               imag_part_word,
	output logic                           sample_ready,
	output logic                           measuring,
	output logic                           aborted,
	// ************************************************
	// register read port
	// ************************************************
	input  wire logic                      word_read,
	output logic                           word_valid,
	output logic [15:0]                    word_data,
	// ************************************************
	// neighbour byte port
	// ************************************************
	input  wire logic                      byte_ready,
	output logic                           byte_valid,
	output logic [7:0]                     byte_data,
	output logic                           byte_last
);
	import fmt_pkg::*;
	typedef enum logic [1:0] {idle_state, sample_state, trailer_state} phase_type;

	// ************************************************
	// configuration registers
	// ************************************************
	sample_kind_type kind_q;
	width_type       width_q;
	run_mode_type    mode_q;
	port_type        port_q;
	logic            trailer_q;
	logic [LEN_W-1:0] request_q;
	logic            setup_err_q;
	wire logic [LEN_W-1:0] eff_len;
	wire logic       len_bad;
	wire logic       changes;
	wire logic       mode_ok;

	// a write counts only if it changes something, so read-back or rewrite keeps the run
	assign changes = cfg_write && (cfg_kind != kind_q || cfg_width != width_q || cfg_mode != mode_q ||
		cfg_len != request_q || cfg_trailer != trailer_q || cfg_port != port_q); // RL22

	// request is kept raw; the calculator derives the length from it every cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			kind_q <= kind_real_only; // RL21
			width_q <= width_thirtytwo;
			mode_q <= single_block_mode;
			port_q <= register_read_port;
			trailer_q <= 1'b0;
			request_q <= RESET_LEN;
		end else if (cfg_write) begin
			kind_q <= cfg_kind;
			width_q <= cfg_width;
			mode_q <= cfg_mode;
			port_q <= cfg_port;
			trailer_q <= cfg_trailer;
			request_q <= (cfg_len == '0) ? LEN_W'(1) : cfg_len; // RL1 RL4
		end
	end

	block_length_calc #(
		.MEM_MULT      (MEM_MULT)
	) u_len (
		.requested_len (request_q),
		.kind          (kind_q),
		.width         (width_q),
		.port          (port_q),
		.effective_len (eff_len),
		.out_of_range  (len_bad)
	);

	// flag follows the clamp so it clears once another setting brings the request in range
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) setup_err_q <= 1'b0;
		else setup_err_q <= len_bad; // RL3 RL4
	end

	// permission table: full-rate wide or complex formats are block only
	wire logic low_filter = (filter_octave_setting <= FILTER_NARROW);
	wire logic c32 = (kind_q == kind_real_imag && width_q == width_thirtytwo);
	wire logic block_only = !extra_decimate && low_filter && (kind_q == kind_real_imag || width_q == width_thirtytwo)
		|| (c32 && extra_decimate && low_filter)
		|| (c32 && !extra_decimate && filter_octave_setting == FILTER_TWO); // RL20
	wire logic refused = c32 && !extra_decimate && low_filter; // RL19 RL20
	assign mode_ok = !refused && !(block_only && mode_q == gapless_run_mode);

	// ************************************************
	// measurement sequencing
	// ************************************************
	phase_type        phase_q;
	logic [LEN_W-1:0] count_q;
	logic [1:0]       status_q;
	logic             abort_q;
	wire logic        ser_busy;
	wire logic        ser_last;
	wire logic        ser_valid;
	wire logic [15:0] ser_data;
	wire logic        out_ready;
	wire logic        take_sample;
	wire logic        block_done;
	wire logic        byte_mode;
	wire logic [3:0]  units;

	assign byte_mode = (port_q == neighbour_byte_port);
	// units per sample: part count times halves or bytes per part
	assign units = (byte_mode ? (width_q == width_thirtytwo ? 4'h4 : 4'h2) : (width_q == width_thirtytwo ? 4'h2 : 4'h1))
		<< (kind_q == kind_real_imag ? 1 : 0); // RL24
	assign sample_ready = (phase_q == sample_state) && !ser_busy;
	assign take_sample = sample_ready && sample_valid;
	assign block_done = (phase_q == sample_state) && !ser_busy && !sample_valid && (count_q == eff_len);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= idle_state;
			count_q <= '0;
			status_q <= 2'h0;
			abort_q <= 1'b0;
		end else begin
			abort_q <= changes && (phase_q != idle_state); // RL22
			if (changes) begin
				phase_q <= idle_state;
			end else begin
				case (phase_q)
					idle_state: begin
						if (arm_trigger && mode_ok) begin
							phase_q <= sample_state;
							count_q <= '0;
							status_q <= 2'h0;
						end
					end
					sample_state: begin
						// accumulate adc events over the block; set wins over the block restart
						status_q <= status_q | {adc_error, adc_overload}; // RL9
						if (take_sample) count_q <= count_q + LEN_W'(1);
						if (block_done) begin
							if (trailer_q) phase_q <= trailer_state;
							else if (mode_q == gapless_run_mode) count_q <= '0; // RL23
							else phase_q <= idle_state; // RL23
						end
					end
					trailer_state: begin
						if (out_ready) begin
							count_q <= '0;
							// an adc event in the restart cycle belongs to the next block: set wins
							status_q <= {adc_error, adc_overload}; // RL9
							phase_q <= (mode_q == gapless_run_mode) ? sample_state : idle_state; // RL23
						end
					end
					default: phase_q <= idle_state;
				endcase
			end
		end
	end

	// skip loading a sample accepted while the count equals the block length
	wire logic room = (count_q != eff_len);
	sample_serializer u_ser (
		.clock       (clock),
		.reset_n     (reset_n),
		.load        (take_sample && room),
		.sample_bits ((width_q == width_sixteen) ?
			{real_part_word[15:0], imag_part_word[15:0], 32'h00000000} :
			{real_part_word, imag_part_word}), // RL13 RL15
		.unit_count  (units),
		.byte_units  (byte_mode),
		.unit_ready  (out_ready),
		.unit_valid  (ser_valid),
		.unit_data   (ser_data),
		.busy        (ser_busy),
		.last_unit   (ser_last)
	);

	// ************************************************
	// output ports
	// ************************************************
	wire logic in_trailer = (phase_q == trailer_state);
	wire logic [7:0] trailer_byte = {6'h00, status_q[ADC_ERROR_BIT], status_q[OVERLOAD_BIT]}; // RL9 RL25
	wire logic unit_out = ser_valid || in_trailer;
	assign out_ready = byte_mode ? byte_ready : word_read;
	assign word_valid = !byte_mode && unit_out;
	assign word_data = in_trailer ? {8'h00, trailer_byte} : ser_data; // RL10 RL25
	assign byte_valid = byte_mode && unit_out;
	// the 32-bit trailer word is zero above the status byte, so only its status byte is sent
	assign byte_data = in_trailer ? trailer_byte : ser_data[7:0]; // RL11 RL15
	assign byte_last = byte_mode && in_trailer; // RL11

	// status and read-back come from registers and the live calculation
	assign sample_kind_select = kind_q;
	assign width_now = width_q;
	assign mode_now = mode_q;
	assign trailer_status_enable = trailer_q;
	assign port_now = port_q;
	assign block_len_now = eff_len; // RL8
	assign setup_error = setup_err_q;
	assign mode_refused = !mode_ok;
	assign rate_limit_bytes = (mode_q == gapless_run_mode) ? GAPLESS_RATE_BYTES : FULL_RATE_BYTES; // RL18
	assign measuring = (phase_q != idle_state);
	assign aborted = abort_q;
	wire logic unused_last = ser_last;
endmodule
`default_nettype wire

// *** tb/fmt_props.sv ***
// assertions on the output formatter top ports
// assumes it is bound into every formatter instance
`timescale 1ns/10ps
`default_nettype none
module fmt_props #(
	parameter int MEM_MULT = 1
) (
	input wire logic                      clock,
	input wire logic                      reset_n,
	input wire fmt_pkg::sample_kind_type  sample_kind_select,
	input wire fmt_pkg::width_type        width_now,
	input wire fmt_pkg::run_mode_type     mode_now,
	input wire logic [fmt_pkg::LEN_W-1:0] block_len_now,
	input wire logic                      mode_refused,
	input wire logic [3:0]                rate_limit_bytes,
	input wire logic [4:0]                filter_octave_setting,
	input wire logic                      extra_decimate,
	input wire logic                      arm_trigger,
	input wire logic                      measuring,
	input wire logic                      aborted,
	input wire logic                      word_valid,
	input wire logic                      word_read,
	input wire logic [15:0]               word_data,
	input wire logic                      byte_valid,
	input wire logic                      byte_ready,
	input wire logic [7:0]                byte_data,
	input wire logic                      byte_last
);
	import fmt_pkg::*;
	// permission table: at low filter settings without extra decimation only real 16-bit output may run gapless
	wire cplx = (sample_kind_select == kind_real_imag);
	wire wide = (width_now == width_thirtytwo);
	wire lowf = (filter_octave_setting <= 5'h1);
	wire c32 = cplx && wide;
	wire blk = (lowf && !extra_decimate && (cplx != wide)) || (lowf && c32 && extra_decimate)
		|| (c32 && !extra_decimate && filter_octave_setting == 5'h2);
	wire want_refuse = (lowf && c32 && !extra_decimate) || (blk && mode_now == gapless_run_mode);
	// longest block shrinks as each sample needs more bytes
	wire [1:0] shift = {1'b0, wide} + {1'b0, cplx};
	wire [LEN_W+3:0] cap = (LEN_W+4)'((BASE_MAX_2B >> shift) * MEM_MULT);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_rate_by_mode: assert property (rate_limit_bytes == (mode_now == gapless_run_mode ? 4'h2 : 4'h4))
		else $error("rate limit does not follow mode");
	a_len_pow_two: assert property (block_len_now != 0 && (block_len_now & (block_len_now - 1)) == 0)
		else $error("block length not a power of two");
	a_len_cap: assert property ({4'h0, block_len_now} <= cap)
		else $error("block length above cap");
	a_refuse_table: assert property (mode_refused == want_refuse)
		else $error("mode permission wrong");
	a_refused_arm: assert property (arm_trigger && mode_refused && !measuring |=> !measuring)
		else $error("refused setup started");
	a_abort_stops: assert property (aborted |-> ##[0:1] !measuring)
		else $error("abort left measurement running");
	a_word_holds: assert property (word_valid && !word_read |=> word_valid && $stable(word_data))
		else $error("word changed before read");
	a_byte_holds: assert property (byte_valid && !byte_ready |=> byte_valid && $stable({byte_data, byte_last}))
		else $error("byte changed before taken");
	a_last_valid: assert property (byte_last |-> byte_valid)
		else $error("last flag without byte");
endmodule
bind sample_block_output_formatter fmt_props #(.MEM_MULT(MEM_MULT)) fmt_props_i (.*);
`default_nettype wire

// *** tb/byte_sink.sv ***
// neighbour module that receives the byte stream
// assumes one clock; stalls in a fixed pattern when slow
`timescale 1ns/10ps
`default_nettype none
module byte_sink (
	input wire logic       clock,
	input wire logic       slow,
	input wire logic       byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic       byte_last,
	output logic           byte_ready
);
	logic [7:0] got [$];
	logic       lst [$];
	int         tick = 0;
	initial byte_ready = 1'b0;
	// ready moves on the falling edge so the formatter sees it settled
	always @(negedge clock) begin
		tick <= tick + 1;
		byte_ready <= !slow || (tick % 3 == 0);
	end
	// a byte counts only where both sides agree; every byte is kept
	always @(posedge clock) begin
		if (byte_valid && byte_ready) begin
			got.push_back(byte_data);
			lst.push_back(byte_last);
		end
	end
endmodule
`default_nettype wire

// *** tb/test_sample_block_output_formatter.sv ***
// testbench for the sample block output formatter
// assumes byte_sink and the bound checker are compiled in
`timescale 1ns/10ps
`default_nettype none
module test_sample_block_output_formatter;
	import fmt_pkg::*;
	logic             clock, reset_n, cfg_write, cfg_trailer, extra_decimate, arm_trigger;
	logic             adc_overload, adc_error, sample_valid, sample_ready, measuring, aborted;
	logic             word_read, word_valid, byte_ready, byte_valid, byte_last, slow;
	logic             trailer_status_enable, setup_error, mode_refused;
	logic [LEN_W-1:0] cfg_len, block_len_now;
	logic [31:0]      real_part_word, imag_part_word, w;
	logic [15:0]      word_data;
	logic [7:0]       byte_data;
	logic [4:0]       filter_octave_setting;
	logic [3:0]       rate_limit_bytes;
	sample_kind_type  cfg_kind, sample_kind_select;
	width_type        cfg_width, width_now;
	run_mode_type     cfg_mode, mode_now;
	port_type         cfg_port, port_now;
	int               errors = 0, num_checks = 0, aborts = 0, i, j;
	sample_block_output_formatter #(.MEM_MULT(1)) sample_block_output_formatter_i (.*);
	byte_sink byte_sink_i (.*);
	// ************************************************
	// shared tasks
	// ************************************************
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// a used-up wait bound is a failure and ends the run
	task automatic tmo(input int n);
		if (n >= 400) begin
			errors++;
			$display("BAD %0t wait ran out", $time);
			end_sim;
		end
	endtask
	task automatic cfg(input sample_kind_type k, width_type wd, run_mode_type m,
			input logic [LEN_W-1:0] n, input logic t, input port_type p);
		@(negedge clock);
		cfg_kind = k;
		cfg_width = wd;
		cfg_mode = m;
		cfg_len = n;
		cfg_trailer = t;
		cfg_port = p;
		cfg_write = 1'b1;
		@(negedge clock);
		cfg_write = 1'b0;
	endtask
	task automatic lc(input logic k, wd, p, input logic [LEN_W-1:0] n, e, input logic er);
		cfg(sample_kind_type'(k), width_type'(wd), single_block_mode, n, 1'b0, port_type'(p));
		repeat (2) @(negedge clock);
		chk(block_len_now, e);
		chk(setup_error, er);
	endtask
	task automatic rf(input logic k, wd, m, input logic [4:0] f, input logic d, e);
		filter_octave_setting = f;
		extra_decimate = d;
		cfg(sample_kind_type'(k), width_type'(wd), run_mode_type'(m), 26'h400, 1'b0, register_read_port);
		@(negedge clock);
		chk(mode_refused, e);
		chk(rate_limit_bytes, m ? 4'h2 : 4'h4);
	endtask
	task automatic arm;
		@(negedge clock);
		arm_trigger = 1'b1;
		@(negedge clock);
		arm_trigger = 1'b0;
	endtask
	task automatic wm(input logic v);
		int n;
		for (n = 0; n < 400 && measuring !== v; n++) @(negedge clock);
		tmo(n);
	endtask
	function automatic logic [31:0] sv(input int s, input int q);
		return (q != 0 ? 32'h5F6E7D8C : 32'hA1B2C3D4) + 32'(s);
	endfunction
	// valid and data stay put until an edge sees ready high
	task automatic feed(input int cnt);
		int s;
		int n;
		for (s = 0; s < cnt; s++) begin
			real_part_word = sv(s, 0);
			imag_part_word = sv(s, 1);
			sample_valid = 1'b1;
			for (n = 0; n < 400; n++) begin
				#1;
				if (sample_ready === 1'b1) break;
				@(negedge clock);
			end
			tmo(n);
			@(negedge clock);
		end
		sample_valid = 1'b0;
	endtask
	task automatic rd(input logic [15:0] e);
		int n;
		@(negedge clock);
		for (n = 0; n < 400 && word_valid !== 1'b1; n++) @(negedge clock);
		tmo(n);
		chk(word_data, e);
		word_read = 1'b1;
		@(negedge clock);
		word_read = 1'b0;
	endtask
	always @(posedge clock) begin
		if (aborted === 1'b1) aborts++;
	end
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ************************************************
	// scenarios
	// ************************************************
	initial begin
		{reset_n, cfg_write, cfg_trailer, extra_decimate, arm_trigger, slow} = 6'h0;
		{adc_overload, adc_error, sample_valid, word_read, cfg_len} = 30'h0;
		{real_part_word, imag_part_word, filter_octave_setting} = 69'h0;
		cfg_kind = kind_real_only;
		cfg_width = width_thirtytwo;
		cfg_mode = single_block_mode;
		cfg_port = register_read_port;
		repeat (20) @(posedge clock);
		@(negedge clock);
		reset_n = 1'b1;
		chk(sample_kind_select, kind_real_only);
		chk(width_now, width_thirtytwo);
		chk(mode_now, single_block_mode);
		chk(trailer_status_enable, 1'b0);
		chk(port_now, register_read_port);
		chk(block_len_now, 26'h400);
		lc(0, 1, 0, 26'h3E8, 26'h400, 0);
		lc(0, 0, 0, 26'h1, 26'h4, 1);
		lc(1, 1, 0, 26'h1, 26'h1, 0);
		lc(1, 1, 1, 26'h1, 26'h2, 1);
		lc(0, 0, 1, 26'h5, 26'h8, 1);
		lc(1, 0, 1, 26'h3, 26'h4, 0);
		lc(0, 0, 0, 26'h4C4B40, 26'h400000, 1);
		lc(1, 1, 0, 26'h1E8480, 26'h100000, 1);
		lc(0, 0, 0, 26'h1E8480, 26'h200000, 0);
		rf(1, 1, 1, 5'h2, 0, 1);
		rf(1, 1, 0, 5'h0, 1, 0);
		rf(1, 0, 1, 5'h1, 0, 1);
		rf(0, 1, 1, 5'h1, 0, 1);
		rf(1, 1, 1, 5'h3, 0, 0);
		rf(0, 0, 1, 5'h0, 0, 0);
		rf(1, 1, 0, 5'h0, 0, 1);
		arm;
		repeat (3) @(negedge clock);
		chk(measuring, 1'b0);
		rf(1, 1, 0, 5'h2, 0, 0);
		cfg(kind_real_imag, width_thirtytwo, single_block_mode, 26'h1, 1'b1, register_read_port);
		adc_overload = 1'b1;
		arm;
		feed(1);
		adc_overload = 1'b0;
		rd(16'hA1B2);
		rd(16'hC3D4);
		rd(16'h5F6E);
		rd(16'h7D8C);
		rd(16'h0001);
		wm(1'b0);
		slow = 1'b1;
		adc_error = 1'b1;
		cfg(kind_real_imag, width_thirtytwo, single_block_mode, 26'h2, 1'b1, neighbour_byte_port);
		arm;
		feed(2);
		adc_error = 1'b0;
		for (j = 0; j < 400 && byte_sink_i.got.size() < 17; j++) @(negedge clock);
		tmo(j);
		for (i = 0; i < 16; i++) begin
			w = sv(i / 8, (i / 4) % 2) >> (8 * (3 - i % 4));
			chk(byte_sink_i.got[i], w & 32'hFF);
			chk(byte_sink_i.lst[i], 1'b0);
		end
		chk(byte_sink_i.got[16], 8'h02);
		chk(byte_sink_i.lst[16], 1'b1);
		cfg(kind_real_imag, width_sixteen, single_block_mode, 26'h4, 1'b0, neighbour_byte_port);
		arm;
		feed(4);
		for (j = 0; j < 400 && byte_sink_i.got.size() < 33; j++) @(negedge clock);
		tmo(j);
		for (i = 0; i < 16; i++) begin
			w = sv(i / 4, (i / 2) % 2) >> (8 * (1 - i % 2));
			chk(byte_sink_i.got[17 + i], w & 32'hFF);
			chk(byte_sink_i.lst[17 + i], 1'b0);
		end
		wm(1'b0);
		filter_octave_setting = 5'h3;
		cfg(kind_real_only, width_thirtytwo, single_block_mode, 26'h400, 1'b0, register_read_port);
		arm;
		wm(1'b1);
		cfg(kind_real_only, width_thirtytwo, single_block_mode, 26'h400, 1'b0, register_read_port);
		repeat (4) @(negedge clock);
		chk(aborts, 0);
		chk(measuring, 1'b1);
		cfg(kind_real_only, width_thirtytwo, single_block_mode, 26'h200, 1'b0, register_read_port);
		repeat (4) @(negedge clock);
		chk(aborts, 1);
		chk(measuring, 1'b0);
		end_sim;
	end
endmodule
`default_nettype wire
